// >>> src/idv_core.sv
/*
  Iterative signed divide unit with an APB register window: sixteen
  working registers, an instruction port and a status word. Each write
  of a divide opcode to the instruction port is one execution; six in a
  row complete a divide. Assumes a single 40 MHz clock and an APB master.
*/
// Chosen here: the APB slave port and the address map.
// Behaviour
// - Fractional preserving divide decoded from fields 1101, 1001, 0010 plus t/s.
// - Fractional form clears register below dividend, quotient low, remainder high.
// - Fractional form is signed 16 by 16 giving 16-bit quotient and remainder.
// - Remainder sign always follows the dividend sign.
// - Negative flag reflects remainder sign at completion.
// - Overflow flag set on overflow at completion, cleared otherwise.
// - Zero flag set when remainder is zero at completion.
// - Carry flag is algorithm working state, meaningless afterwards.
// - Zero divisor raises the arithmetic trap on the first execution.
// - Partial state survives interrupts between iterations.
// - Six executions plus one repeat cycle, one program word.
// - Integer preserving divide decoded from fields 1101, 1000, low 110.
// - Integer form divides 16-bit or 32-bit dividend by 16-bit divisor.
// - Quotient to low dividend register, remainder to that register number with bit 0 set.
// - Separate fields select divisor, high and low dividend registers.
// - Quotient not fitting 16 signed bits sets overflow.
// - Size bit selects 16-bit dividend when 0, 32-bit when 1.
`timescale 1ns/1ps
`default_nettype none
module idv_core
  import idv_pkg::*;
#(
  parameter int ITERS = IDV_ITERS,
  parameter int BITS  = IDV_BITS
) (
  input  wire logic        sys_clk,  // 40 MHz core clock
  input  wire logic        resetn,   // Async reset, active low
  input  wire logic        psel,     // APB select
  input  wire logic        penable,  // APB enable
  input  wire logic        pwrite,   // APB direction
  input  wire logic [7:0]  paddr,    // APB byte address
  input  wire logic [31:0] pwdata,   // APB write data
  output logic      [31:0] prdata,   // APB read data
  output logic             pready,   // APB ready
  output logic             pslverr,  // APB error
  output logic             trap_o,   // Arithmetic error trap pulse
  output logic             done_o    // Divide committed pulse
);
  localparam int STEPS = (IDV_DW + BITS - 1) / BITS;

  initial begin
    if (ITERS != IDV_ITERS) $error("idv_core: ITERS must be %0d", IDV_ITERS);
    if (BITS < 1 || STEPS > ITERS - 1) $error("idv_core: BITS too small");
  end

  logic [IDV_DW-1:0] w_q [IDV_NREGS];
  logic [23:0]       ins_q;
  logic [2:0]        iter_q;
  logic              active_q;
  idv_op_t           op_q;
  logic [3:0]        dst_lo_q;
  logic [3:0]        dst_hi_q;
  logic [IDV_DW-1:0] rem_q;
  logic [IDV_DW-1:0] shin_q;
  logic [IDV_DW-1:0] quo_q;
  logic [IDV_DW-1:0] dv_q;
  logic              qneg_q;
  logic              dneg_q;
  logic              ovpre_q;
  logic              st_c_q;
  logic              st_z_q;
  logic              st_ov_q;
  logic              st_n_q;
  logic              st_trap_q;
  logic [31:0]       prdata_q;
  logic              pready_q;
  logic              pslverr_q;
  logic              trap_q;
  logic              done_q;

  assign prdata  = prdata_q;
  assign pready  = pready_q;
  assign pslverr = pslverr_q;
  assign trap_o  = trap_q;
  assign done_o  = done_q;

  // Bus decode
  logic    acc;
  logic    wr_w;
  logic    issue;
  logic    mapped;
  idv_op_t dec_op;
  assign acc    = psel && penable && pready_q;
  assign mapped = (paddr <= IDV_ADDR_WN) || paddr == IDV_ADDR_INS || paddr == IDV_ADDR_STA;
  assign dec_op = idv_decode(pwdata[23:0]);
  assign wr_w   = acc && pwrite && paddr <= IDV_ADDR_WN && paddr[1:0] == 2'b00;
  assign issue  = acc && pwrite && paddr == IDV_ADDR_INS && dec_op != IDV_OP_NONE;

  // Operand fetch for the first execution
  logic [3:0]        f_t;
  logic [3:0]        f_v;
  logic [3:0]        f_s;
  logic [31:0]       f_dvd;
  logic [31:0]       f_mag;
  logic [IDV_DW-1:0] f_dv;
  logic [IDV_DW-1:0] f_dvmag;
  logic              first;
  logic              last;
  assign f_t   = pwdata[14:11];
  assign f_v   = pwdata[10:7];
  assign f_s   = pwdata[3:0];
  assign first = issue && (!active_q || pwdata[23:0] != ins_q);
  assign last  = issue && !first && iter_q == 3'(ITERS - 1);

  always_comb begin
    if (dec_op == IDV_OP_FRAC) begin
      // pair Wm:0000, scaled to a Q15 quotient
      f_dvd = {w_q[f_t][IDV_DW-1], w_q[f_t], 15'h0000};
    end else if (pwdata[IDV_SIZE_BIT]) begin
      // high word from t, low word from v
      f_dvd = {w_q[f_t], w_q[f_v]};
    end else begin
      // word variant sign-extends the low word
      f_dvd = {{IDV_DW{w_q[f_v][IDV_DW-1]}}, w_q[f_v]};
    end
    f_mag   = f_dvd[31] ? 32'(-f_dvd) : f_dvd;
    f_dv    = w_q[f_s];
    f_dvmag = f_dv[IDV_DW-1] ? IDV_DW'(-f_dv) : f_dv;
  end

  // Restoring slice, fed from fresh operands on the first execution
  logic [IDV_DW-1:0] s_rem;
  logic [IDV_DW-1:0] s_shin;
  logic [IDV_DW-1:0] s_quo;
  logic [IDV_DW-1:0] s_dv;
  logic [IDV_DW-1:0] n_rem;
  logic [IDV_DW-1:0] n_shin;
  logic [IDV_DW-1:0] n_quo;
  logic              n_c;
  assign s_rem  = first ? f_mag[31:16] : rem_q;
  assign s_shin = first ? f_mag[15:0]  : shin_q;
  assign s_quo  = first ? '0 : quo_q;
  assign s_dv   = first ? f_dvmag : dv_q;

  idv_step #(.W(IDV_DW), .BITS(BITS)) u_step (
    .rem_i   (s_rem),
    .shin_i  (s_shin),
    .quo_i   (s_quo),
    .dv_i    (s_dv),
    .rem_o   (n_rem),
    .shin_o  (n_shin),
    .quo_o   (n_quo),
    .carry_o (n_c)
  );

  // Final signed results
  logic [IDV_DW-1:0] r_quo;
  logic [IDV_DW-1:0] r_rem;
  logic              r_ov;
  always_comb begin
    r_quo = qneg_q ? IDV_DW'(-quo_q) : quo_q;
    r_rem = dneg_q ? IDV_DW'(-rem_q) : rem_q;
    // quotient must fit a signed 16-bit word
    r_ov  = ovpre_q || (qneg_q ? quo_q > 16'h8000 : quo_q[IDV_DW-1]);
  end

  // Sequence control; state lives here, untouched by other accesses
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      active_q <= 1'b0;
      iter_q   <= 3'h0;
      ins_q    <= 24'h000000;
      op_q     <= IDV_OP_NONE;
      dst_lo_q <= 4'h0;
      dst_hi_q <= 4'h0;
    end else if (issue) begin
      if (first) begin
        ins_q    <= pwdata[23:0];
        op_q     <= dec_op;
        active_q <= (w_q[f_s] != '0);
        iter_q   <= 3'h1;
        dst_lo_q <= (dec_op == IDV_OP_FRAC) ? f_t - 4'h1 : f_v;
        dst_hi_q <= (dec_op == IDV_OP_FRAC) ? f_t : (f_v | 4'h1);
      end else if (last) begin
        active_q <= 1'b0;
        iter_q   <= 3'h0;
      end else begin
        iter_q <= iter_q + 3'h1;
      end
    end
  end

  // Datapath working state
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      rem_q   <= '0;
      shin_q  <= '0;
      quo_q   <= '0;
      dv_q    <= '0;
      qneg_q  <= 1'b0;
      dneg_q  <= 1'b0;
      ovpre_q <= 1'b0;
      st_c_q  <= 1'b0;
    end else if (issue && (first || iter_q < 3'(STEPS))) begin
      if (first) begin
        dv_q    <= f_dvmag;
        dneg_q  <= f_dvd[31];
        qneg_q  <= f_dvd[31] ^ f_dv[IDV_DW-1];
        ovpre_q <= f_mag[31:16] >= f_dvmag;
      end
      rem_q  <= n_rem;
      shin_q <= n_shin;
      quo_q  <= n_quo;
      st_c_q <= n_c;
    end
  end

  // Working registers
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      for (int i = 0; i < IDV_NREGS; i++) w_q[i] <= '0;
    end else if (wr_w) begin
      w_q[paddr[5:2]] <= pwdata[IDV_DW-1:0];
    end else if (issue && first && dec_op == IDV_OP_FRAC) begin
      // clear the register below the dividend
      w_q[f_t - 4'h1] <= '0;
    end else if (last) begin
      w_q[dst_lo_q] <= r_quo;
      w_q[dst_hi_q] <= r_rem;
    end
  end

  // Status flags and event pulses
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      st_z_q    <= IDV_STA_RST[IDV_SB_Z];
      st_ov_q   <= IDV_STA_RST[IDV_SB_OV];
      st_n_q    <= IDV_STA_RST[IDV_SB_N];
      st_trap_q <= IDV_STA_RST[IDV_SB_TRAP];
      trap_q    <= 1'b0;
      done_q    <= 1'b0;
    end else begin
      trap_q <= issue && first && w_q[f_s] == '0;
      done_q <= last;
      if (issue && first) begin
        st_trap_q <= (w_q[f_s] == '0);
      end
      if (last) begin
        st_n_q  <= r_rem[IDV_DW-1];
        st_ov_q <= r_ov;
        st_z_q  <= (r_rem == '0);
      end
    end
  end

  // APB answer: one wait state, ready for one cycle
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h0000_0000;
    end else begin
      pready_q  <= psel && penable && !pready_q;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h0000_0000;
      if (psel && penable && !pready_q) begin
        pslverr_q <= !mapped || (pwrite && paddr == IDV_ADDR_INS && dec_op == IDV_OP_NONE)
                     || (pwrite && paddr == IDV_ADDR_STA);
        if (!pwrite && paddr <= IDV_ADDR_WN) begin
          prdata_q <= {16'h0000, w_q[paddr[5:2]]};
        end else if (!pwrite && paddr == IDV_ADDR_INS) begin
          prdata_q <= {8'h00, ins_q};
        end else if (!pwrite && paddr == IDV_ADDR_STA) begin
          prdata_q[IDV_SB_C]              <= st_c_q;
          prdata_q[IDV_SB_Z]              <= st_z_q;
          prdata_q[IDV_SB_OV]             <= st_ov_q;
          prdata_q[IDV_SB_N]              <= st_n_q;
          prdata_q[IDV_SB_TRAP]           <= st_trap_q;
          prdata_q[IDV_SB_ACT]            <= active_q;
          prdata_q[IDV_SB_ITER+2:IDV_SB_ITER] <= iter_q;
        end
      end
    end
  end

  default clocking @(posedge sys_clk); endclocking
  default disable iff (!resetn);

  // zero divisor traps on first execution
  zero_trap_a: assert property (issue && first && w_q[f_s] == '0 |=> trap_o && !active_q)
    else $error("zero divisor did not trap");
  // commit exactly on the sixth execution
  six_commit_a: assert property (done_o |-> $past(iter_q) == 3'(ITERS - 1) && !active_q)
    else $error("commit not on sixth execution");
  neg_flag_a: assert property (done_o |-> st_n_q == w_q[dst_hi_q][IDV_DW-1])
    else $error("negative flag wrong");
  zero_flag_a: assert property (done_o |-> st_z_q == (w_q[dst_hi_q] == '0))
    else $error("zero flag wrong");
  rem_sign_a: assert property (done_o && w_q[dst_hi_q] != '0 |-> w_q[dst_hi_q][IDV_DW-1] == dneg_q)
    else $error("remainder sign differs from dividend");
  // lower register cleared on first fractional execution
  frac_clear_a: assert property (issue && first && dec_op == IDV_OP_FRAC && !wr_w |=> w_q[dst_lo_q] == '0)
    else $error("fractional low register not cleared");
  // flags hold until the final execution
  flag_hold_a: assert property (!last |=> $stable({st_n_q, st_z_q, st_ov_q}))
    else $error("flags changed before completion");
  word_ovf_a: assert property (last && op_q == IDV_OP_INT && !qneg_q && quo_q == 16'h8000 |=> st_ov_q)
    else $error("word overflow not flagged");
  bus_pulse_a: assert property (pready |=> !pready)
    else $error("ready held two cycles");

  frac_done_c: cover property (done_o && op_q == IDV_OP_FRAC);
  int_done_c:  cover property (done_o && op_q == IDV_OP_INT && !st_ov_q);
  ovf_c:       cover property (done_o && st_ov_q);
  trap_c:      cover property (trap_o);
endmodule : idv_core
`default_nettype wire

// >>> src/idv_pkg.sv
/*
  Shared constants for the iterative divide unit: register map, opcode
  fields, status bit positions, sequence counts and the opcode decoder.
  Assumes a 32-bit APB master and 16-bit working registers.
*/
package idv_pkg;
  localparam int          IDV_DW       = 16;
  localparam int          IDV_NREGS    = 16;
  // Register map (byte addresses)
  localparam logic [7:0]  IDV_ADDR_W0  = 8'h00;
  localparam logic [7:0]  IDV_ADDR_WN  = 8'h3c;
  localparam logic [7:0]  IDV_ADDR_INS = 8'h40;
  localparam logic [7:0]  IDV_ADDR_STA = 8'h44;
  // Opcode fields
  localparam logic [7:0]  IDV_OPC_FRAC = 8'hd9;
  localparam logic [7:0]  IDV_OPC_INT  = 8'hd8;
  localparam logic [6:0]  IDV_FRAC_LOW = 7'h02;
  localparam logic [2:0]  IDV_INT_LOW  = 3'h6;
  localparam int          IDV_SIZE_BIT = 11;
  // Status word bit positions
  localparam int          IDV_SB_C     = 0;
  localparam int          IDV_SB_Z     = 1;
  localparam int          IDV_SB_OV    = 2;
  localparam int          IDV_SB_N     = 3;
  localparam int          IDV_SB_TRAP  = 4;
  localparam int          IDV_SB_ACT   = 5;
  localparam int          IDV_SB_ITER  = 8;
  localparam logic [31:0] IDV_STA_RST  = 32'h0000_0000;
  // Sequence shape
  localparam int          IDV_ITERS    = 6;
  localparam int          IDV_BITS     = 4;

  typedef enum logic [1:0] {IDV_OP_NONE, IDV_OP_FRAC, IDV_OP_INT} idv_op_t;

  function automatic idv_op_t idv_decode(input logic [23:0] ins);
    idv_op_t op;
    op = IDV_OP_NONE;
    if (ins[23:16] == IDV_OPC_FRAC && !ins[15] && ins[10:4] == IDV_FRAC_LOW) begin
      op = IDV_OP_FRAC;
    end else if (ins[23:16] == IDV_OPC_INT && !ins[15] && ins[6:4] == IDV_INT_LOW) begin
      op = IDV_OP_INT;
    end
    return op;
  endfunction : idv_decode
endpackage : idv_pkg

// >>> src/idv_step.sv
/*
  Combinational restoring-division slice: retires BITS quotient bits.
  Assumes the partial remainder is already below the divisor.
*/
`timescale 1ns/1ps
`default_nettype none
module idv_step #(
  parameter int W    = 16,
  parameter int BITS = 4
) (
  input  wire logic [W-1:0] rem_i,   // Partial remainder
  input  wire logic [W-1:0] shin_i,  // Dividend bits still to enter, MSB first
  input  wire logic [W-1:0] quo_i,   // Quotient so far
  input  wire logic [W-1:0] dv_i,    // Divisor magnitude
  output logic      [W-1:0] rem_o,   // Next remainder
  output logic      [W-1:0] shin_o,  // Remaining dividend bits
  output logic      [W-1:0] quo_o,   // Next quotient
  output logic              carry_o  // Last subtract outcome
);
  initial begin
    if (BITS < 1 || BITS > W) $error("idv_step: BITS out of range");
  end

  always_comb begin
    logic [W:0] r;
    r       = {1'b0, rem_i};
    shin_o  = shin_i;
    quo_o   = quo_i;
    carry_o = 1'b0;
    for (int i = 0; i < BITS; i++) begin
      r      = {r[W-1:0], shin_o[W-1]};
      shin_o = {shin_o[W-2:0], 1'b0};
      // Carry doubles as the subtract-succeeded bit
      carry_o = (r >= {1'b0, dv_i});
      if (carry_o) r = r - {1'b0, dv_i};
      quo_o = {quo_o[W-2:0], carry_o};
    end
    rem_o = r[W-1:0];
  end
endmodule : idv_step
`default_nettype wire

// >>> verification/idv_seq_model.sv
/*
  Sequencer model: APB master standing in for the decoder and the
  repeat loop that issue each divide opcode six times in a row.
  Assumes the idv_core APB port on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none
module idv_seq_model
  import idv_pkg::*;
(
  input  wire logic        sys_clk,  // Core clock
  output logic             psel,     // APB select
  output logic             penable,  // APB enable
  output logic             pwrite,   // APB direction
  output logic [7:0]       paddr,    // APB address
  output logic [31:0]      pwdata,   // APB write data
  input  wire logic [31:0] prdata,   // APB read data
  input  wire logic        pready,   // APB ready
  input  wire logic        pslverr   // APB error
);
  initial begin
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 8'h00;
    pwdata  = 32'h0;
  end

  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] rd, output logic err);
    @(posedge sys_clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    // Read right after the edge: values are still those sampled at it
    for (int i = 0; i < 64; i++) begin
      @(posedge sys_clk);
      if (pready === 1'b1) break;
    end
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    // Released bus shows no stale value
    paddr   <= ~a;
    pwdata  <= ~d;
  endtask : xfer

  task automatic repeat_div(input logic [23:0] op, input int k, output logic err);
    logic [31:0] rd;
    for (int i = 0; i < k; i++) begin
      xfer(1'b1, IDV_ADDR_INS, {8'h00, op}, rd, err);
    end
  endtask : repeat_div
endmodule : idv_seq_model
`default_nettype wire

// >>> verification/iterative_divide_unit_tb.sv
/*
  Self-checking bench for the divide unit: register access and divide
  sequences through the sequencer model, results checked by value.
  Assumes idv_pkg, idv_core and idv_seq_model are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
module iterative_divide_unit_tb import idv_pkg::*;;
  logic        sys_clk, resetn, psel, penable, pwrite, pready, pslverr, trap_o, done_o, er;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rv;
  int          n_fail = 0, comparisons = 0, n_trap = 0, n_done = 0, t0, t1;
  logic [7:0]  bad_a [4] = '{IDV_ADDR_STA, IDV_ADDR_INS, IDV_ADDR_INS, 8'h80};
  logic [31:0] bad_d [4] = '{32'h1, 32'hd94039, 32'hd80174, 32'h5};

  idv_core dut_u (.sys_clk(sys_clk), .resetn(resetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .trap_o(trap_o), .done_o(done_o));
  idv_seq_model seq_u (.sys_clk(sys_clk), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end

  // Counts cycles high, so a one-cycle pulse adds exactly one
  always @(posedge sys_clk) begin
    if (trap_o === 1'b1) n_trap++;
    if (done_o === 1'b1) n_done++;
  end

  task automatic end_of_test;
    $display("comparisons %0d n_fail %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : end_of_test

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  task automatic chk_n(input string nm, input int exp, input int got);
    comparisons++;
    if (got != exp) begin
      n_fail++;
      $display("mismatch %s expected %0d seen %0d", nm, exp, got);
    end
  endtask : chk_n

  task automatic rd(input logic [7:0] a);
    seq_u.xfer(1'b0, a, 32'h0, rv, er);
  endtask : rd

  task automatic wrw(input int n, input logic [31:0] d);
    seq_u.xfer(1'b1, IDV_ADDR_W0 + 8'(4 * n), d, rv, er);
  endtask : wrw

  task automatic chk_w(input int n, input logic [15:0] exp);
    rd(IDV_ADDR_W0 + 8'(4 * n));
    chk("working register", {16'h0, exp}, rv);
  endtask : chk_w

  task automatic chk_flags(input logic n, input logic ov, input logic z);
    logic [31:0] m;
    m = (32'h1 << IDV_SB_N) | (32'h1 << IDV_SB_OV) | (32'h1 << IDV_SB_Z);
    rd(IDV_ADDR_STA);
    chk("status flags", (32'(n) << IDV_SB_N) | (32'(ov) << IDV_SB_OV) | (32'(z) << IDV_SB_Z), rv & m);
  endtask : chk_flags

  task automatic chk_ov;
    rd(IDV_ADDR_STA);
    chk("overflow flag", 32'h1, (rv >> IDV_SB_OV) & 32'h1);
  endtask : chk_ov

  task automatic div(input logic [23:0] op, input int k);
    seq_u.repeat_div(op, k, er);
    // Let the done or trap pulse reach the counters
    repeat (2) @(posedge sys_clk);
  endtask : div

  initial begin
    repeat (20000) @(posedge sys_clk);
    n_fail++;
    end_of_test();
  end

  initial begin
    resetn = 1'b0;
    repeat (8) @(posedge sys_clk);
    resetn <= 1'b1;
    rd(IDV_ADDR_STA);
    chk("status reset", IDV_STA_RST, rv);
    chk_w(5, 16'h0000);
    wrw(5, 32'habcd_1234);
    chk_w(5, 16'h1234);
    // Fractional divide with accesses between executions
    wrw(7, 32'h1234);
    wrw(8, 32'h1000);
    wrw(9, 32'h4000);
    t0 = n_done;
    div(24'hd94029, 3);
    chk_w(7, 16'h0000);
    chk_w(8, 16'h1000);
    wrw(9, 32'h7777);
    div(24'hd94029, 2);
    chk_n("done pulses", t0, n_done);
    div(24'hd94029, 1);
    chk("accepted", 32'h0, {31'h0, er});
    chk_n("done pulses", t0 + 1, n_done);
    chk_w(7, 16'h2000);
    chk_w(8, 16'h0000);
    chk_w(9, 16'h7777);
    chk_flags(1'b0, 1'b0, 1'b1);
    wrw(4, 32'h8002);
    wrw(5, 32'h8001);
    div(24'hd92025, 6);
    chk_w(3, 16'h7ffe);
    chk_w(4, 16'h8002);
    chk_flags(1'b1, 1'b0, 1'b0);
    // Dividend not below divisor
    wrw(10, 32'h4000);
    wrw(11, 32'h2000);
    div(24'hd9502b, 6);
    chk_ov();
    wrw(2, 32'h3000);
    wrw(4, 32'h0027);
    div(24'hd80164, 6);
    chk_w(2, 16'h013b);
    chk_w(3, 16'h0003);
    chk_flags(1'b0, 1'b0, 1'b0);
    wrw(6, 32'hfff6);
    wrw(9, 32'h0003);
    div(24'hd80369, 6);
    chk_w(6, 16'hfffd);
    chk_w(7, 16'hffff);
    chk_flags(1'b1, 1'b0, 1'b0);
    // Even low register, high word from the next one
    wrw(12, 32'h2500);
    wrw(13, 32'hff42);
    wrw(4, 32'h2200);
    div(24'hd86e64, 6);
    chk("accepted", 32'h0, {31'h0, er});
    chk_w(12, 16'hfa6b);
    chk_w(13, 16'hef00);
    chk_flags(1'b1, 1'b0, 1'b0);
    wrw(0, 32'h8000);
    wrw(5, 32'hffff);
    div(24'hd80065, 6);
    chk_ov();
    // Zero divisor on the first execution
    wrw(3, 32'h1000);
    wrw(15, 32'h0000);
    t0 = n_trap;
    t1 = n_done;
    div(24'hd9182f, 1);
    rd(IDV_ADDR_STA);
    chk("trap status", 32'h1, (rv >> IDV_SB_TRAP) & 32'h1);
    chk_n("trap pulses", t0 + 1, n_trap);
    chk_n("done pulses", t1, n_done);
    for (int i = 0; i < 4; i++) begin
      seq_u.xfer(1'b1, bad_a[i], bad_d[i], rv, er);
      chk("error response", 32'h1, {31'h0, er});
    end
    rd(8'h80);
    chk("error response", 32'h1, {31'h0, er});
    end_of_test();
  end
endmodule : iterative_divide_unit_tb
`default_nettype wire
